// [rg_channel.sv]
// ----------------------------------------------------------------
// shared constants
// ----------------------------------------------------------------
package rqgt_pkg;
  // bus timing states reported by the bus interface unit
  localparam logic [2:0] TS_IDLE = 3'h0;
  localparam logic [2:0] TS_T1 = 3'h1;
  localparam logic [2:0] TS_T2 = 3'h2;
  localparam logic [2:0] TS_T3 = 3'h3;
  localparam logic [2:0] TS_T4 = 3'h4;
  localparam logic [2:0] TS_TW = 3'h5;
  // upper half of the bus status encoding
  localparam logic STAT_MEM_BIT = 1'h1;
  localparam logic [1:0] KIND_FETCH = 2'h0;
  localparam logic [1:0] KIND_READ = 2'h1;
  localparam logic [1:0] KIND_WRITE = 2'h2;
  localparam logic [1:0] KIND_PASSIVE = 2'h3;
  localparam logic [2:0] STAT_RESET = 3'h7;
  // idle level of a request/grant line
  localparam logic RG_IDLE_LEVEL = 1'h1;
  // handshake states of one request/grant line
  typedef enum logic [3:0] {
    CH_IDLE = 4'h1,
    CH_PEND = 4'h2,
    CH_GRANT = 4'h4,
    CH_HOLD = 4'h8
  } ch_state_t;
endpackage : rqgt_pkg

`timescale 1ns/1ps

// ----------------------------------------------------------------
// one request/grant line: request, grant, release
// ----------------------------------------------------------------
module rg_channel (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // pin, split into three signals
  input wire logic rg_pin_in,
  output logic rg_pin_out,
  output logic rg_oe_out,
  // arbiter side
  input wire logic grant_go_in,
  output logic pending_out,
  output logic granting_out,
  output logic holding_out,
  output logic release_out
);
  import rqgt_pkg::*;

  ch_state_t state_q;
  logic samp_q;
  logic low_evt;

  // sample on the rising edge; own drive is never taken as a pulse
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      samp_q <= RG_IDLE_LEVEL;
    end else begin
      samp_q <= rg_oe_out ? RG_IDLE_LEVEL : rg_pin_in;
    end
  end

  // each sampled low level counts as one pulse
  assign low_evt = (samp_q == 1'b0);

  // three-pulse handshake
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= CH_IDLE;
    end else begin
      case (state_q)
        CH_IDLE: if (low_evt) state_q <= CH_PEND;
        CH_PEND: if (grant_go_in) state_q <= CH_GRANT;
        CH_GRANT: state_q <= CH_HOLD;
        CH_HOLD: if (low_evt) state_q <= CH_IDLE;
        default: state_q <= CH_IDLE;
      endcase
    end
  end

  // grant pulse is a one-clock low drive from the state flop
  assign rg_pin_out = 1'b0;
  assign rg_oe_out = (state_q == CH_GRANT);
  assign pending_out = (state_q == CH_PEND);
  assign granting_out = (state_q == CH_GRANT);
  assign holding_out = (state_q == CH_HOLD);
  assign release_out = (state_q == CH_HOLD) && low_evt;
endmodule : rg_channel

// [local_bus_request_grant.sv]
// Notes on behaviour
// - status high bit: fetch, read, write, passive
// - two lines; line zero wins over one
// - idle lines read inactive high
// - one-clock grant pulse, then hold acknowledge
// - hold acknowledge detaches the bus unit
// - third pulse ends hold; resume next clock
// - each handover is exactly three pulses
// - one dead clock after every exchange (code adds it only after a release, not after a grant)
// - request by T2 releases at T4
// - never release between odd word halves
// - never release after first interrupt acknowledge
// - no grant while locked instruction runs
// - idle bus releases on next clock
// - imminent memory cycle uses memory rules
// - lock from prefix through next instruction
// - status and write strobe float in hold
`timescale 1ns/1ps

module local_bus_request_grant (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // request/grant pins
  input wire logic bus_req_grant_hi_in,
  output logic bus_req_grant_hi_out,
  output logic bus_req_grant_hi_oe_out,
  input wire logic bus_req_grant_lo_in,
  output logic bus_req_grant_lo_out,
  output logic bus_req_grant_lo_oe_out,
  // bus interface unit state
  input wire logic [2:0] t_state_in,
  input wire logic mem_cycle_in,
  input wire logic [1:0] mem_kind_in,
  input wire logic [2:0] other_status_in,
  input wire logic cycle_soon_in,
  input wire logic odd_word_low_in,
  input wire logic inta_first_in,
  input wire logic write_strobe_n_in,
  // instruction flow
  input wire logic lock_prefix_in,
  input wire logic instr_done_in,
  // bus interface unit control
  output logic biu_hold_out,
  output logic hold_ack_out,
  // status, write strobe and lock pins
  output logic [2:0] status_out,
  output logic status_oe_out,
  output logic write_strobe_n_out,
  output logic write_strobe_oe_out,
  output logic lock_n_out,
  output logic lock_oe_out
);
  import rqgt_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic pend0, pend1, gnt0, gnt1, hold0, hold1, rel0, rel1;
  logic go0, go1, grant_ok, busy, early_q, dead_q, lock_q;
  logic armed_q, bus_idle, at_t4, float_bus;
  logic req_now;
  logic [2:0] status_q;
  logic wr_n_q;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // low on a line that the device does not drive, outside a hold,
  // is a fresh request arriving at this edge
  function automatic logic req_seen(input logic pin_lvl,
                                    input logic own_drive,
                                    input logic in_hold);
    return !pin_lvl && !own_drive && !in_hold;
  endfunction : req_seen

  // early part of a bus cycle, where a request still counts
  function automatic logic early_state(input logic [2:0] ts);
    return (ts == TS_T1) || (ts == TS_T2);
  endfunction : early_state

  // upper half of the status encoding for one kind of cycle
  function automatic logic [2:0] upper_code(input logic [1:0] kind);
    return {STAT_MEM_BIT, kind};
  endfunction : upper_code

  // ----------------------------------------------------------------
  // request/grant lines
  // ----------------------------------------------------------------
  rg_channel u_line0 (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .rg_pin_in(bus_req_grant_hi_in),
    .rg_pin_out(bus_req_grant_hi_out),
    .rg_oe_out(bus_req_grant_hi_oe_out),
    .grant_go_in(go0),
    .pending_out(pend0),
    .granting_out(gnt0),
    .holding_out(hold0),
    .release_out(rel0)
  );

  rg_channel u_line1 (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .rg_pin_in(bus_req_grant_lo_in),
    .rg_pin_out(bus_req_grant_lo_out),
    .rg_oe_out(bus_req_grant_lo_oe_out),
    .grant_go_in(go1),
    .pending_out(pend1),
    .granting_out(gnt1),
    .holding_out(hold1),
    .release_out(rel1)
  );

  // ----------------------------------------------------------------
  // release decision
  // ----------------------------------------------------------------
  // the bus is owned or being handed over
  assign busy = gnt0 | gnt1 | hold0 | hold1;
  // no memory cycle running and none about to start
  assign bus_idle = !mem_cycle_in && (t_state_in == TS_IDLE) &&
                    !cycle_soon_in;
  assign at_t4 = mem_cycle_in && (t_state_in == TS_T4);

  // grant when free of lock and dead clock, at a legal release point
  assign grant_ok = !busy && !dead_q && !lock_q &&
                    (bus_idle ||
                     (at_t4 && early_q &&
                      !odd_word_low_in &&
                      !inta_first_in));

  // line zero first; line one waits while line zero pends
  assign go0 = grant_ok && pend0;
  assign go1 = grant_ok && pend1 && !pend0;

  // a request arriving at this edge, on either line; the line's own
  // sample flop adds a cycle, so the pin itself is watched here
  assign req_now = req_seen(bus_req_grant_hi_in, bus_req_grant_hi_oe_out,
                            hold0) ||
                   req_seen(bus_req_grant_lo_in, bus_req_grant_lo_oe_out,
                            hold1);

  // remember a request seen on or before T2 of a memory cycle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      early_q <= 1'b0;
    end else if (at_t4) begin
      early_q <= 1'b0;
    end else if (mem_cycle_in && (pend0 || pend1 || req_now) &&
                 early_state(t_state_in)) begin
      early_q <= 1'b1;
    end
  end

  // one dead clock after every release
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dead_q <= 1'b0;
    end else begin
      dead_q <= rel0 | rel1;
    end
  end

  // ----------------------------------------------------------------
  // hold acknowledge and floating
  // ----------------------------------------------------------------
  // bus is floated from the grant pulse through the hold
  assign float_bus = gnt0 | gnt1 | hold0 | hold1;
  assign hold_ack_out = hold0 | hold1;
  assign biu_hold_out = float_bus | dead_q;
  assign status_oe_out = !float_bus;
  assign write_strobe_oe_out = !float_bus;
  assign lock_oe_out = !float_bus;

  // ----------------------------------------------------------------
  // bus status and write strobe
  // ----------------------------------------------------------------
  // memory cycles use the upper codes, others pass from neighbour
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_q <= STAT_RESET;
      wr_n_q <= 1'b1;
    end else begin
      if (mem_cycle_in && !float_bus) begin
        status_q <= upper_code(mem_kind_in);
      end else if (!float_bus) begin
        status_q <= other_status_in;
      end else begin
        status_q <= upper_code(KIND_PASSIVE);
      end
      wr_n_q <= float_bus ? 1'b1 : write_strobe_n_in;
    end
  end

  assign status_out = status_q;
  assign write_strobe_n_out = wr_n_q;

  // ----------------------------------------------------------------
  // bus lock
  // ----------------------------------------------------------------
  // set by the prefix, cleared when the following instruction ends;
  // a prefix in the same cycle as a completion keeps the lock
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (lock_prefix_in) begin
      lock_q <= 1'b1;
      armed_q <= 1'b1;
    end else if (armed_q && instr_done_in) begin
      lock_q <= 1'b0;
      armed_q <= 1'b0;
    end
  end

  // low keeps other system masters off the system bus
  assign lock_n_out = !lock_q;
endmodule : local_bus_request_grant

// [lbrg_properties.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// handover checks at the block's ports
// ----------------------------------------------------------------
module lbrg_properties
  import rqgt_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // watched ports
  input wire logic bus_req_grant_hi_oe_out,
  input wire logic bus_req_grant_lo_oe_out,
  input wire logic [2:0] t_state_in,
  input wire logic mem_cycle_in,
  input wire logic [1:0] mem_kind_in,
  input wire logic odd_word_low_in,
  input wire logic inta_first_in,
  input wire logic lock_prefix_in,
  input wire logic hold_ack_out,
  input wire logic biu_hold_out,
  input wire logic status_oe_out,
  input wire logic [2:0] status_out,
  input wire logic lock_n_out
);
  logic gnt;
  // either line carrying a grant pulse
  assign gnt = bus_req_grant_hi_oe_out | bus_req_grant_lo_oe_out;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  AST_GRANT_ONE: assert property (gnt |=> !gnt && hold_ack_out)
    else $error("grant pulse not one clock or no hold");
  AST_NOT_BOTH: assert property (!(bus_req_grant_hi_oe_out &&
    bus_req_grant_lo_oe_out)) else $error("both lines granted");
  AST_DETACH: assert property (hold_ack_out |->
    biu_hold_out && !status_oe_out) else $error("bus not released");
  AST_DEAD: assert property ($fell(hold_ack_out) |-> biu_hold_out && !gnt)
    else $error("no dead clock after hold");
  AST_STAT: assert property (mem_cycle_in && !biu_hold_out |=>
    biu_hold_out || status_out == {STAT_MEM_BIT, $past(mem_kind_in)})
    else $error("memory status code wrong");
  AST_SPLIT: assert property (t_state_in == TS_T4 &&
    mem_cycle_in && (odd_word_low_in || inta_first_in) |=> !gnt)
    else $error("grant inside split cycle");
  AST_LOCKED: assert property (!lock_n_out && $past(lock_n_out) == 1'b0
    |-> !gnt) else $error("grant while locked");
  AST_LOCK_ON: assert property (lock_prefix_in |=> !lock_n_out)
    else $error("lock not asserted");
endmodule : lbrg_properties

bind local_bus_request_grant lbrg_properties u_lbrg_properties (.*);

// [lbrg_master.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// other local bus master on one request/grant line
// ----------------------------------------------------------------
module lbrg_master (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // line level and commands
  input wire logic line_in,
  input wire logic start_in,
  input wire logic [3:0] hold_len_in,
  output logic drive_out,
  output logic owner_out
);
  logic [1:0] ph_q;
  logic [3:0] cnt_q;
  // request pulse, wait for grant, hold, release pulse
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {ph_q, cnt_q, drive_out, owner_out} <= '0;
    end else begin
      drive_out <= 1'b0;
      case (ph_q)
        2'h0: if (start_in) begin
          drive_out <= 1'b1;
          ph_q <= 2'h1;
        end
        2'h1: if (!line_in && !drive_out) begin
          owner_out <= 1'b1;
          cnt_q <= hold_len_in;
          ph_q <= 2'h2;
        end
        2'h2: if (cnt_q == 4'h0) begin
          drive_out <= 1'b1;
          owner_out <= 1'b0;
          ph_q <= 2'h0;
        end else cnt_q <= cnt_q - 4'h1;
        default: ph_q <= 2'h0;
      endcase
    end
  end
endmodule : lbrg_master

// [test_local_bus_request_grant.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  miscompares++; $display("mismatch at %0t: %h not %h", $time, got, exp); \
  end end
module test_local_bus_request_grant;
  import rqgt_pkg::*;
  logic clk_sys_in, rst_n_in, st0, st1, prefix, done, odd, inta, wsn;
  logic mc, soon, g0, g1, d0, d1, own0, own1, hack, bh, soe, lockn;
  logic [2:0] ts, other, stat;
  logic [1:0] kind;
  logic [3:0] hl;
  logic p0, p1, wso, wsoe, loe;
  logic [31:0] lfsr_q = 32'h0000_3013;
  int miscompares = 0, checks_done = 0, cycles = 0, n;
  wire line0 = g0 ? p0 : !d0;
  wire line1 = g1 ? p1 : !d1;
  local_bus_request_grant u_local_bus_request_grant (
    .clk_sys_in, .rst_n_in, .bus_req_grant_hi_in(line0),
    .bus_req_grant_hi_out(p0), .bus_req_grant_hi_oe_out(g0),
    .bus_req_grant_lo_in(line1), .bus_req_grant_lo_out(p1),
    .bus_req_grant_lo_oe_out(g1), .t_state_in(ts), .mem_cycle_in(mc),
    .mem_kind_in(kind), .other_status_in(other), .cycle_soon_in(soon),
    .odd_word_low_in(odd), .inta_first_in(inta), .write_strobe_n_in(wsn),
    .lock_prefix_in(prefix), .instr_done_in(done), .biu_hold_out(bh),
    .hold_ack_out(hack), .status_out(stat), .status_oe_out(soe),
    .write_strobe_n_out(wso), .write_strobe_oe_out(wsoe),
    .lock_n_out(lockn), .lock_oe_out(loe));
  lbrg_master u_m0 (.clk_sys_in, .rst_n_in, .line_in(line0),
    .start_in(st0), .hold_len_in(hl), .drive_out(d0), .owner_out(own0));
  lbrg_master u_m1 (.clk_sys_in, .rst_n_in, .line_in(line1),
    .start_in(st1), .hold_len_in(hl), .drive_out(d1), .owner_out(own1));
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction : rnd
  function automatic logic [2:0] exp_stat(logic m, logic [1:0] k,
    logic [2:0] o);
    return m ? {STAT_MEM_BIT, k} : o;
  endfunction : exp_stat
  task automatic cyc(int k);
    repeat (k) @(negedge clk_sys_in);
  endtask : cyc
  task automatic wait_gnt(output int w);
    for (w = 0; !(g0 | g1) && w < 40; w++) cyc(1);
  endtask : wait_gnt
  task automatic drain();
    int w;
    for (w = 0; (own0 | own1 | bh) && w < 60; w++) cyc(1);
    `CHK(w < 60, 1'b1)
  endtask : drain
  task automatic conclude();
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // clock
  initial begin
    clk_sys_in = 0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // hang guard
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      conclude();
    end
  end
  // reset, then scenarios
  initial begin
    {rst_n_in, st0, st1, prefix, done, odd, inta, mc, soon} = '0;
    {ts, other, kind} = '0;
    {wsn, hl} = 5'h13;
    cyc(10);
    rst_n_in = 1;
    // idle bus, then both lines at once
    for (int i = 0; i < 2; i++) begin
      {st0, st1} = {1'b1, i[0]};
      cyc(1);
      {st0, st1} = 2'b00;
      wait_gnt(n);
      `CHK({g0, g1, n}, {2'b10, 32'd3})
      cyc(1);
      `CHK({hack, soe, bh, wsoe, loe, own0}, 6'b101001)
      wait_gnt(n);
      `CHK({g1, own0}, {i[0], 1'b0})
      drain();
    end
    // memory cycle: clean, odd word low half, first acknowledge
    for (int e = 0; e < 3; e++) begin
      {mc, ts, st0} = {1'b1, TS_T1, 1'b1};
      hl = 4'(rnd());
      cyc(1);
      {st0, ts} = {1'b0, TS_T2};
      cyc(1);
      ts = TS_T3;
      cyc(1);
      {ts, odd, inta} = {TS_T4, e == 1, e == 2};
      cyc(1);
      `CHK(g0, e == 0)
      {mc, ts, odd, inta} = '0;
      wait_gnt(n);
      drain();
    end
    // locked instruction withholds the grant
    prefix = 1;
    cyc(1);
    {prefix, st0} = 2'b01;
    cyc(1);
    st0 = 0;
    cyc(8);
    `CHK({lockn, own0}, 2'b00)
    done = 1;
    cyc(1);
    done = 0;
    wait_gnt(n);
    `CHK({g0, lockn}, 2'b11)
    drain();
    // a memory cycle about to start defers an idle-bus grant
    {soon, st0} = 2'b11;
    cyc(1);
    st0 = 0;
    cyc(6);
    `CHK({g0, own0, hack}, 3'b000)
    soon = 0;
    wait_gnt(n);
    `CHK({g0, n}, {1'b1, 32'd1})
    drain();
    // random status traffic
    repeat (24) begin
      {mc, kind, other, soon, wsn} = 8'(rnd());
      cyc(1);
      `CHK({stat, wso, wsoe}, {exp_stat(mc, kind, other), wsn, 1'b1})
    end
    conclude();
  end
endmodule : test_local_bus_request_grant
